// ===== rtl/frm_manager.sv
/*
  Reconfiguration manager top: chooses a load source (flash slot, host stream or
  JTAG), drives the configuration port through the shifter and keeps the PCIe
  identity and endpoint alive throughout. Assumes the flash controller, PCIe core
  and JTAG chain sit outside and meet it over the ports below on core_clk.
*/
//
// Summary of operation
// - Endpoint ready at once after power up
// - Flash holds four selectable image slots
// - Power-up slot taken from hardware switch
// - Flash writable by JTAG or host
// - Host selects slot then issues reload
// - Host may stream image for configuration
// - Streamed image never written to flash
// - JTAG may configure user FPGA directly
// - Manager drives configuration handshake itself
// - PCIe config space kept across reloads
// - Same device identity after any reload
`timescale 1ns/1ps
`default_nettype none
module frm_manager (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [frm_pkg::FRM_SLOT_W-1:0] slotSwitch,
  input wire frm_pkg::frm_cmd_t hostCmd,
  input wire frm_pkg::frm_byte_t hostStream,
  output logic hostStreamReady,
  input wire logic hostFlashWrite,
  input wire logic jtagFlashWrite,
  input wire logic [frm_pkg::FRM_FLASH_ADDR_W-1:0] flashWrAddr,
  input wire logic [7:0] flashWrData,
  output logic flashReadReq,
  output logic [frm_pkg::FRM_FLASH_ADDR_W-1:0] flashReadAddr,
  input wire frm_pkg::frm_byte_t flashRead,
  output logic flashWriteEn,
  output logic [frm_pkg::FRM_FLASH_ADDR_W-1:0] flashWriteAddr,
  output logic [7:0] flashWriteData,
  input wire logic cfgInitPin,
  input wire logic cfgDonePin,
  output frm_pkg::frm_cfg_out_t cfgOut,
  output logic jtagBypassEn,
  output frm_pkg::frm_stat_t status,
  output logic [15:0] pcieVendorId,
  output logic [15:0] pcieDeviceId,
  output logic [31:0] pcieCfgData,
  input wire logic [3:0] pcieCfgIndex,
  input wire logic pcieCfgWrite,
  input wire logic [31:0] pcieCfgWrData
);
  import frm_pkg::*;

  typedef enum logic [1:0] {
    MG_BOOT = 2'h0,
    MG_IDLE = 2'h1,
    MG_LOAD = 2'h2
  } frm_mg_state_t;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] syncA_reg, syncB_reg;
  logic [FRM_SLOT_W-1:0] swA_reg, swB_reg;
  logic initSync, doneSync;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      swA_reg <= FRM_SLOT_RESET;
      swB_reg <= FRM_SLOT_RESET;
    end else if (clkEn) begin
      syncA_reg <= {cfgDonePin, cfgInitPin, 1'b0};
      syncB_reg <= syncA_reg;
      swA_reg <= slotSwitch;
      swB_reg <= swA_reg;
    end
  end
  assign initSync = syncB_reg[1];
  assign doneSync = syncB_reg[2];

  // ****************************************************************
  // Manager state
  // ****************************************************************
  frm_mg_state_t state_reg, state_next;
  frm_src_t src_reg, src_next;
  frm_status_t stat_reg, stat_next;
  logic [FRM_SLOT_W-1:0] slot_reg, slot_next;
  logic [FRM_FLASH_ADDR_W-1:0] rdAddr_reg, rdAddr_next;
  logic [1:0] bootWait_reg, bootWait_next;
  logic shStart, shFinished, shFailed, shReady;
  frm_byte_t shByte;

  always_comb begin
    state_next = state_reg;
    src_next = src_reg;
    stat_next = stat_reg;
    slot_next = slot_reg;
    rdAddr_next = rdAddr_reg;
    bootWait_next = bootWait_reg;
    shStart = 1'b0;
    unique case (state_reg)
      MG_BOOT: begin
        // Four cycles let the switch pass its synchroniser before it is used
        bootWait_next = bootWait_reg + 1'b1;
        if (bootWait_reg == 2'h3) begin
          slot_next = swB_reg;
          src_next = FRM_SRC_FLASH;
          state_next = MG_LOAD;
          stat_next = FRM_ST_BUSY;
          rdAddr_next = {swB_reg, {FRM_SLOT_ADDR_LSB{1'b0}}};
          shStart = 1'b1;
        end
      end
      MG_IDLE: begin
        if (hostCmd.reload) begin
          slot_next = hostCmd.slot;
          src_next = FRM_SRC_FLASH;
          rdAddr_next = {hostCmd.slot, {FRM_SLOT_ADDR_LSB{1'b0}}};
          state_next = MG_LOAD;
          stat_next = FRM_ST_BUSY;
          shStart = 1'b1;
        end else if (hostCmd.streamStart) begin
          src_next = FRM_SRC_HOST;
          state_next = MG_LOAD;
          stat_next = FRM_ST_BUSY;
          shStart = 1'b1;
        end else if (hostCmd.jtagStart) begin
          src_next = FRM_SRC_JTAG;
          state_next = MG_LOAD;
          stat_next = FRM_ST_BUSY;
          shStart = 1'b1;
        end
      end
      MG_LOAD: begin
        if (src_reg == FRM_SRC_FLASH && flashRead.valid && shReady) begin
          rdAddr_next = rdAddr_reg + 1'b1;
        end
        if (shFinished) begin
          stat_next = FRM_ST_DONE;
          state_next = MG_IDLE;
        end else if (shFailed) begin
          stat_next = FRM_ST_FAIL;
          state_next = MG_IDLE;
        end
      end
      default: state_next = MG_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= MG_BOOT;
      src_reg <= FRM_SRC_FLASH;
      stat_reg <= FRM_ST_IDLE;
      slot_reg <= FRM_SLOT_RESET;
      rdAddr_reg <= '0;
      bootWait_reg <= 2'h0;
    end else if (clkEn) begin
      state_reg <= state_next;
      src_reg <= src_next;
      stat_reg <= stat_next;
      slot_reg <= slot_next;
      rdAddr_reg <= rdAddr_next;
      bootWait_reg <= bootWait_next;
    end
  end

  // ****************************************************************
  // Data source mux
  // ****************************************************************
  always_comb begin
    shByte = '0;
    hostStreamReady = 1'b0;
    flashReadReq = 1'b0;
    if (state_reg == MG_LOAD) begin
      unique case (src_reg)
        FRM_SRC_FLASH: begin
          shByte = flashRead;
          flashReadReq = shReady;
        end
        FRM_SRC_HOST: begin
          // Bytes go straight to the config port, nothing reaches flash
          shByte = hostStream;
          hostStreamReady = shReady;
        end
        default: shByte = '0;
      endcase
    end
  end
  assign flashReadAddr = rdAddr_reg;
  assign jtagBypassEn = (state_reg == MG_LOAD) && (src_reg == FRM_SRC_JTAG);

  frm_cfg_shifter uShifter (
    .core_clk(core_clk),
    .reset(reset),
    .clkEn(clkEn),
    .start(shStart),
    .bypass(src_next == FRM_SRC_JTAG),
    .inByte(shByte),
    .inReady(shReady),
    .initDone(initSync),
    .cfgDone(doneSync),
    .cfgOut(cfgOut),
    .finished(shFinished),
    .failed(shFailed)
  );

  // ****************************************************************
  // Flash programming path
  // ****************************************************************
  logic fwEn_reg;
  logic [FRM_FLASH_ADDR_W-1:0] fwAddr_reg;
  logic [7:0] fwData_reg;

  // Both ports share one address and data path; the write pulses are merged
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fwEn_reg <= 1'b0;
      fwAddr_reg <= '0;
      fwData_reg <= 8'h00;
    end else if (clkEn) begin
      fwEn_reg <= hostFlashWrite || jtagFlashWrite;
      fwAddr_reg <= flashWrAddr;
      fwData_reg <= flashWrData;
    end
  end
  assign flashWriteEn = fwEn_reg;
  assign flashWriteAddr = fwAddr_reg;
  assign flashWriteData = fwData_reg;

  // ****************************************************************
  // PCIe configuration space, untouched by any reload
  // ****************************************************************
  logic [31:0] cfgSpace_reg [16];
  logic [31:0] cfgRd_reg;

  // Only the PCIe write port and reset touch this storage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        cfgSpace_reg[i] <= 32'h0000_0000;
      end
      cfgRd_reg <= 32'h0000_0000;
    end else if (clkEn) begin
      if (pcieCfgWrite && pcieCfgIndex != 4'h0) begin
        cfgSpace_reg[pcieCfgIndex] <= pcieCfgWrData;
      end
      cfgRd_reg <= (pcieCfgIndex == 4'h0) ? {FRM_DEVICE_ID_DEF, FRM_VENDOR_ID_DEF}
                                          : cfgSpace_reg[pcieCfgIndex];
    end
  end
  assign pcieCfgData = cfgRd_reg;
  assign pcieVendorId = FRM_VENDOR_ID_DEF;
  assign pcieDeviceId = FRM_DEVICE_ID_DEF;

  assign status.status = stat_reg;
  assign status.source = src_reg;
  assign status.slot = slot_reg;
  assign status.endpointReady = 1'b1;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_boot_slot_switch: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && state_reg == MG_BOOT && bootWait_reg == 2'h3 |=> slot_reg == $past(swB_reg))
    else $error("boot slot not taken from switch");
  a_reload_slot: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && state_reg == MG_IDLE && hostCmd.reload
      |=> state_reg == MG_LOAD && slot_reg == $past(hostCmd.slot))
    else $error("reload did not load requested slot");
  a_busy_on_start: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && shStart |=> stat_reg == FRM_ST_BUSY)
    else $error("status not busy after load start");
  a_done_status: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && state_reg == MG_LOAD && shFinished |=> stat_reg == FRM_ST_DONE)
    else $error("status not done after finish");
  a_fail_status: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && state_reg == MG_LOAD && shFailed |=> stat_reg == FRM_ST_FAIL)
    else $error("status not failed after error");
  a_stream_no_flash: assert property (@(posedge core_clk) disable iff (reset)
    src_reg == FRM_SRC_HOST && !hostFlashWrite && !jtagFlashWrite |=> !flashWriteEn)
    else $error("streamed image reached flash");
  a_identity_stable: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && pcieCfgIndex == 4'h0 |=> pcieCfgData == {FRM_DEVICE_ID_DEF, FRM_VENDOR_ID_DEF}
      && pcieVendorId == FRM_VENDOR_ID_DEF && pcieDeviceId == FRM_DEVICE_ID_DEF)
    else $error("device identity changed");
  a_endpoint_ready: assert property (@(posedge core_clk)
    status.endpointReady)
    else $error("endpoint not ready");
  a_cfg_kept: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && !pcieCfgWrite && state_reg == MG_LOAD
      |=> cfgSpace_reg[3] == $past(cfgSpace_reg[3]))
    else $error("config space changed during reload");
  a_jtag_bypass: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && state_reg == MG_IDLE && !hostCmd.reload && !hostCmd.streamStart
      && hostCmd.jtagStart |=> jtagBypassEn)
    else $error("jtag bypass not opened");

  c_flash_reload: cover property (@(posedge core_clk) disable iff (reset)
    state_reg == MG_LOAD && src_reg == FRM_SRC_FLASH && shFinished);
  c_stream_load: cover property (@(posedge core_clk) disable iff (reset)
    state_reg == MG_LOAD && src_reg == FRM_SRC_HOST && shFinished);
  c_jtag_load: cover property (@(posedge core_clk) disable iff (reset)
    state_reg == MG_LOAD && src_reg == FRM_SRC_JTAG && shFinished);
  c_load_fail: cover property (@(posedge core_clk) disable iff (reset) shFailed);
endmodule
`default_nettype wire

// ===== rtl/frm_pkg.sv
/*
  Package for the reconfiguration manager: image slots, load sources, status codes,
  configuration handshake timing and the packed carriers shared by the design files.
  Assumes a single 250 MHz core clock domain.
*/
package frm_pkg;

  // ****************************************************************
  // Image store
  // ****************************************************************
  localparam int FRM_IMAGE_SLOTS = 4;
  localparam int FRM_SLOT_W = 2;
  localparam logic [1:0] FRM_SLOT_RESET = 2'h0;
  localparam int FRM_FLASH_ADDR_W = 24;
  localparam int FRM_SLOT_ADDR_LSB = 22;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int FRM_CLK_MHZ = 250;
  localparam int FRM_PROG_PULSE_NS = 500;
  localparam int FRM_PROG_PULSE_CYC = (FRM_PROG_PULSE_NS * FRM_CLK_MHZ + 999) / 1000;
  localparam int FRM_DONE_TIMEOUT_CYC = 1000000;
  localparam int FRM_CNT_W = 24;

  // ****************************************************************
  // Identity, arbitrary values
  // ****************************************************************
  localparam logic [15:0] FRM_VENDOR_ID_DEF = 16'h1234;
  localparam logic [15:0] FRM_DEVICE_ID_DEF = 16'h5678;

  typedef enum logic [1:0] {
    FRM_SRC_FLASH = 2'h0,
    FRM_SRC_HOST = 2'h1,
    FRM_SRC_JTAG = 2'h2
  } frm_src_t;

  typedef enum logic [1:0] {
    FRM_ST_IDLE = 2'h0,
    FRM_ST_BUSY = 2'h1,
    FRM_ST_DONE = 2'h2,
    FRM_ST_FAIL = 2'h3
  } frm_status_t;

  // Host command port
  typedef struct packed {
    logic reload;
    logic streamStart;
    logic jtagStart;
    logic [FRM_SLOT_W-1:0] slot;
  } frm_cmd_t;

  // Byte stream, used for both flash read data and host image data
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } frm_byte_t;

  // Low-level pins of the user FPGA configuration port
  typedef struct packed {
    logic progN;
    logic cclk;
    logic [7:0] data;
  } frm_cfg_out_t;

  typedef struct packed {
    frm_status_t status;
    frm_src_t source;
    logic [FRM_SLOT_W-1:0] slot;
    logic endpointReady;
  } frm_stat_t;

endpackage

// ===== rtl/frm_cfg_shifter.sv
/*
  Configuration port driver: pulses program, waits for init, clocks bytes into the
  user FPGA and checks done. Assumes init and done are already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
module frm_cfg_shifter (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic start,
  input wire logic bypass,
  input wire frm_pkg::frm_byte_t inByte,
  output logic inReady,
  input wire logic initDone,
  input wire logic cfgDone,
  output frm_pkg::frm_cfg_out_t cfgOut,
  output logic finished,
  output logic failed
);
  import frm_pkg::*;

  typedef enum logic [2:0] {
    SH_IDLE = 3'h0,
    SH_PROG = 3'h1,
    SH_INIT = 3'h2,
    SH_DATA = 3'h3,
    SH_DONE = 3'h4
  } frm_sh_state_t;

  frm_sh_state_t state_reg, state_next;
  logic [FRM_CNT_W-1:0] cnt_reg, cnt_next;
  frm_cfg_out_t out_reg, out_next;
  logic fin_reg, fin_next, fail_reg, fail_next;

  assign inReady = (state_reg == SH_DATA) && !out_reg.cclk;
  assign cfgOut = out_reg;
  assign finished = fin_reg;
  assign failed = fail_reg;

  // ****************************************************************
  // Handshake sequencer
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    out_next = out_reg;
    fin_next = 1'b0;
    fail_next = 1'b0;
    unique case (state_reg)
      SH_IDLE: begin
        out_next.cclk = 1'b0;
        if (start) begin
          out_next.progN = 1'b0;
          cnt_next = FRM_CNT_W'(FRM_PROG_PULSE_CYC);
          state_next = SH_PROG;
        end
      end
      SH_PROG: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == FRM_CNT_W'(1)) begin
          out_next.progN = 1'b1;
          cnt_next = FRM_CNT_W'(FRM_DONE_TIMEOUT_CYC);
          state_next = SH_INIT;
        end
      end
      SH_INIT: begin
        cnt_next = cnt_reg - 1'b1;
        if (initDone) begin
          state_next = bypass ? SH_DONE : SH_DATA;
          cnt_next = FRM_CNT_W'(FRM_DONE_TIMEOUT_CYC);
        end else if (cnt_reg == '0) begin
          fail_next = 1'b1;
          state_next = SH_IDLE;
        end
      end
      SH_DATA: begin
        // Cclk runs at half rate; data changes only as cclk rises, in the same cycle
        if (out_reg.cclk) begin
          out_next.cclk = 1'b0;
        end else if (inByte.valid) begin
          out_next.data = inByte.data;
          out_next.cclk = 1'b1;
          if (inByte.last) begin
            state_next = SH_DONE;
          end
        end
      end
      SH_DONE: begin
        // Startup clocks only; while JTAG owns the pins cclk stays low
        out_next.cclk = bypass ? 1'b0 : ~out_reg.cclk;
        cnt_next = cnt_reg - 1'b1;
        if (cfgDone) begin
          fin_next = 1'b1;
          out_next.cclk = 1'b0;
          state_next = SH_IDLE;
        end else if (cnt_reg == '0) begin
          fail_next = 1'b1;
          out_next.cclk = 1'b0;
          state_next = SH_IDLE;
        end
      end
      default: state_next = SH_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= SH_IDLE;
      cnt_reg <= '0;
      out_reg <= '{progN: 1'b1, cclk: 1'b0, data: 8'h00};
      fin_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
      fin_reg <= fin_next;
      fail_reg <= fail_next;
    end
  end

  a_prog_low_pulse: assert property (@(posedge core_clk) disable iff (reset)
    clkEn && state_reg == SH_IDLE && start |=> !out_reg.progN)
    else $error("program pin not asserted on start");
  a_no_data_early: assert property (@(posedge core_clk) disable iff (reset)
    (state_reg == SH_PROG || state_reg == SH_INIT) |-> !out_reg.cclk)
    else $error("cclk toggled before init");
endmodule
`default_nettype wire

// ===== tb/frm_partner.sv
/*
  Far-side model for the reconfiguration manager: a configuration flash that
  answers reads in the same cycle, and a user FPGA that answers the program,
  init and done handshake.
  Assumes one core_clk domain and the manager's flash and configuration ports.
*/
`timescale 1ns/1ps
`default_nettype none
module frm_partner #(
  parameter int LEN = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic flashReadReq,
  input wire logic [frm_pkg::FRM_FLASH_ADDR_W-1:0] flashReadAddr,
  output frm_pkg::frm_byte_t flashRead,
  input wire frm_pkg::frm_cfg_out_t cfgOut,
  input wire logic jtagBypassEn,
  output logic cfgInitPin,
  output logic cfgDonePin,
  output logic [7:0] byteCnt,
  output logic [7:0] cksum
);
  import frm_pkg::*;
  logic [7:0] idleToggle_reg = 8'h5A;
  logic [7:0] initCnt_reg;
  logic [7:0] bypCnt_reg;
  logic cclkPrev_reg;

  // ****************************************************************
  // Flash: slot picked by the top address bits, data follows address
  // ****************************************************************
  // Unrequested data toggles so a stale byte is never mistaken for a good one
  always_comb begin
    flashRead.valid = flashReadReq;
    flashRead.last = flashReadReq && (flashReadAddr[7:0] == 8'(LEN - 1));
    flashRead.data = flashReadReq ? (flashReadAddr[7:0] ^ {flashReadAddr[23:22], 6'h00}) :
      idleToggle_reg;
  end

  // ****************************************************************
  // User FPGA: init after program, bytes on cclk, done at the end
  // ****************************************************************
  always @(posedge core_clk) begin
    idleToggle_reg <= ~idleToggle_reg;
    cclkPrev_reg <= cfgOut.cclk;
    if (reset || !cfgOut.progN) begin
      initCnt_reg <= 8'h00;
      bypCnt_reg <= 8'h00;
      byteCnt <= 8'h00;
      cksum <= 8'h00;
      cfgInitPin <= 1'b0;
      cfgDonePin <= 1'b0;
    end else begin
      if (initCnt_reg < 8'h0A) begin
        initCnt_reg <= initCnt_reg + 8'h01;
      end else begin
        cfgInitPin <= 1'b1;
      end
      // Clocks after the last byte are startup clocks, not image data
      if (cfgOut.cclk && !cclkPrev_reg && byteCnt < 8'(LEN)) begin
        byteCnt <= byteCnt + 8'h01;
        cksum <= cksum ^ cfgOut.data;
      end
      if (jtagBypassEn) begin
        bypCnt_reg <= bypCnt_reg + 8'h01;
      end
      if (byteCnt == 8'(LEN) || bypCnt_reg == 8'h14) begin
        cfgDonePin <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/frm_manager_tb_top.sv
/*
  Self-checking bench for the reconfiguration manager: power-up load, flash
  reloads, host streaming, JTAG load, flash writes and config space upkeep.
  Assumes frm_partner stands in for the flash and the user FPGA.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH %0t %s", $time, m); end end
module frm_manager_tb_top;
  import frm_pkg::*;
  localparam int LEN = 16;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic [1:0] slotSwitch = 2'h2;
  frm_cmd_t hostCmd = '0;
  frm_byte_t hostStream = '0;
  logic hostStreamReady;
  logic hostFlashWrite = 1'b0;
  logic jtagFlashWrite = 1'b0;
  logic [23:0] flashWrAddr = 24'h000000;
  logic [7:0] flashWrData = 8'h00;
  logic flashReadReq;
  logic [23:0] flashReadAddr;
  frm_byte_t flashRead;
  logic flashWriteEn;
  logic [23:0] flashWriteAddr;
  logic [7:0] flashWriteData;
  logic cfgInitPin;
  logic cfgDonePin;
  frm_cfg_out_t cfgOut;
  logic jtagBypassEn;
  frm_stat_t status;
  logic [15:0] pcieVendorId;
  logic [15:0] pcieDeviceId;
  logic [31:0] pcieCfgData;
  logic [3:0] pcieCfgIndex = 4'h0;
  logic pcieCfgWrite = 1'b0;
  logic [31:0] pcieCfgWrData = 32'h00000000;
  logic [7:0] byteCnt;
  logic [7:0] cksum;
  int error_cnt = 0;
  int checks = 0;
  int streamWr = 0;

  always #2 core_clk = ~core_clk;

  frm_manager u_dut (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
    .slotSwitch(slotSwitch), .hostCmd(hostCmd), .hostStream(hostStream),
    .hostStreamReady(hostStreamReady), .hostFlashWrite(hostFlashWrite),
    .jtagFlashWrite(jtagFlashWrite), .flashWrAddr(flashWrAddr), .flashWrData(flashWrData),
    .flashReadReq(flashReadReq), .flashReadAddr(flashReadAddr), .flashRead(flashRead),
    .flashWriteEn(flashWriteEn), .flashWriteAddr(flashWriteAddr),
    .flashWriteData(flashWriteData), .cfgInitPin(cfgInitPin), .cfgDonePin(cfgDonePin),
    .cfgOut(cfgOut), .jtagBypassEn(jtagBypassEn), .status(status),
    .pcieVendorId(pcieVendorId), .pcieDeviceId(pcieDeviceId), .pcieCfgData(pcieCfgData),
    .pcieCfgIndex(pcieCfgIndex), .pcieCfgWrite(pcieCfgWrite), .pcieCfgWrData(pcieCfgWrData));

  frm_partner #(.LEN(LEN)) u_partner (.core_clk(core_clk), .reset(reset),
    .flashReadReq(flashReadReq), .flashReadAddr(flashReadAddr), .flashRead(flashRead),
    .cfgOut(cfgOut), .jtagBypassEn(jtagBypassEn), .cfgInitPin(cfgInitPin),
    .cfgDonePin(cfgDonePin), .byteCnt(byteCnt), .cksum(cksum));

  // A streamed image must never reach the flash
  always @(posedge core_clk) begin
    if (status.source === FRM_SRC_HOST && flashWriteEn === 1'b1) begin
      streamWr <= streamWr + 1;
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic summarize();
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  function automatic logic [7:0] img_sum(input logic [1:0] s, input logic host);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < LEN; i++) begin
      r = r ^ (host ? 8'(8'hA0 + i) : (8'(i) ^ {s, 6'h00}));
    end
    return r;
  endfunction

  task automatic wait_status(input frm_status_t s, input int lim);
    int n;
    n = 0;
    while (status.status !== s && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    `CHK(status.status, s, "status wait")
  endtask

  task automatic pulse_cmd(input frm_cmd_t c);
    hostCmd <= c;
    @(posedge core_clk);
    hostCmd <= '0;
  endtask

  task automatic expect_start(input frm_src_t src, input logic [1:0] slot);
    int n;
    wait_status(FRM_ST_BUSY, 20);
    `CHK(status.source, src, "load source")
    `CHK(status.slot, slot, "load slot")
    n = 0;
    while (cfgOut.progN !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    `CHK(n, FRM_PROG_PULSE_CYC, "program pulse length")
  endtask

  task automatic expect_end(input frm_src_t src, input logic [7:0] sum);
    wait_status(FRM_ST_DONE, 3000);
    if (src != FRM_SRC_JTAG) begin
      `CHK(byteCnt, 8'(LEN), "bytes into user FPGA")
      `CHK(cksum, sum, "image contents")
    end
    `CHK(pcieVendorId, FRM_VENDOR_ID_DEF, "vendor id")
    `CHK(pcieDeviceId, FRM_DEVICE_ID_DEF, "device id")
  endtask

  task automatic flash_load(input logic [1:0] s);
    int n;
    n = 0;
    while (flashReadReq !== 1'b1 && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    `CHK(flashReadAddr, {s, 22'h000000}, "slot base address")
    expect_end(FRM_SRC_FLASH, img_sum(s, 1'b0));
  endtask

  task automatic cfg_access(input logic [3:0] idx, input logic wr, input logic [31:0] d);
    pcieCfgIndex <= idx;
    pcieCfgWrite <= wr;
    pcieCfgWrData <= d;
    @(posedge core_clk);
    pcieCfgWrite <= 1'b0;
    @(posedge core_clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_cfgspace();
    cfg_access(4'h3, 1'b1, 32'hCAFE0003);
    cfg_access(4'h0, 1'b1, 32'hFFFFFFFF);
    cfg_access(4'h0, 1'b0, 32'h00000000);
    `CHK(pcieCfgData, {FRM_DEVICE_ID_DEF, FRM_VENDOR_ID_DEF}, "id word")
  endtask

  task automatic t_reload(input logic [1:0] s, input logic refuse);
    pulse_cmd('{1'b1, 1'b0, 1'b0, s});
    expect_start(FRM_SRC_FLASH, s);
    if (refuse) begin
      pulse_cmd('{1'b0, 1'b1, 1'b0, 2'h0});
    end
    flash_load(s);
    `CHK(status.source, FRM_SRC_FLASH, "command during load ignored")
    cfg_access(4'h3, 1'b0, 32'h00000000);
    `CHK(pcieCfgData, 32'hCAFE0003, "config space kept")
  endtask

  task automatic t_stream();
    int n;
    pulse_cmd('{1'b0, 1'b1, 1'b0, 2'h1});
    expect_start(FRM_SRC_HOST, 2'h1);
    for (int i = 0; i < LEN; i++) begin
      hostStream <= '{1'b1, i == LEN - 1, 8'(8'hA0 + i)};
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (hostStreamReady !== 1'b1 && n < 500);
    end
    hostStream <= '0;
    expect_end(FRM_SRC_HOST, img_sum(2'h0, 1'b1));
    `CHK(streamWr, 0, "streamed image kept off flash")
  endtask

  task automatic t_jtag();
    int n;
    pulse_cmd('{1'b0, 1'b0, 1'b1, 2'h0});
    expect_start(FRM_SRC_JTAG, 2'h1);
    n = 0;
    while (jtagBypassEn !== 1'b1 && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    `CHK(jtagBypassEn, 1'b1, "pins handed to JTAG")
    expect_end(FRM_SRC_JTAG, 8'h00);
    `CHK(jtagBypassEn, 1'b0, "pins taken back")
  endtask

  task automatic t_freeze();
    clkEn <= 1'b0;
    pulse_cmd('{1'b1, 1'b0, 1'b0, 2'h2});
    repeat (2) @(posedge core_clk);
    `CHK(status.status, FRM_ST_DONE, "frozen manager took command")
    `CHK(cfgOut.progN, 1'b1, "frozen manager pulsed program")
    clkEn <= 1'b1;
  endtask

  task automatic t_flashwr(input logic viaJtag, input logic [23:0] a, input logic [7:0] d);
    hostFlashWrite <= !viaJtag;
    jtagFlashWrite <= viaJtag;
    flashWrAddr <= a;
    flashWrData <= d;
    @(posedge core_clk);
    hostFlashWrite <= 1'b0;
    jtagFlashWrite <= 1'b0;
    @(posedge core_clk);
    `CHK(flashWriteEn, 1'b1, "flash write issued")
    `CHK(flashWriteAddr, a, "flash write address")
    `CHK(flashWriteData, d, "flash write data")
    @(posedge core_clk);
    `CHK(flashWriteEn, 1'b0, "flash write one cycle")
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (3) @(posedge core_clk);
    `CHK(status.endpointReady, 1'b1, "endpoint ready in reset")
    `CHK(cfgOut.progN, 1'b1, "program idle in reset")
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    expect_start(FRM_SRC_FLASH, 2'h2);
    `CHK(status.endpointReady, 1'b1, "endpoint ready while loading")
    flash_load(2'h2);
    t_cfgspace();
    t_reload(2'h3, 1'b1);
    t_reload(2'h0, 1'b0);
    t_reload(2'h1, 1'b0);
    t_stream();
    t_jtag();
    t_freeze();
    t_flashwr(1'b0, 24'hC00010, 8'h3C);
    t_flashwr(1'b1, 24'h400020, 8'hA5);
    summarize();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
